/* File: src/spisp_top.sv */
// serial peripheral port, master or slave, with its port d pin control.
// assumes a one-cycle register port and pins resolved outside by the enables.
//
// What this block does
// - unselected slave releases its data-out pin
// - master shows each out bit half a clock before the latching edge
// - one byte takes exactly eight clock cycles, in and out together
// - master rate bits divide e clock by 2, 4, 16, 32; ignored as slave
// - select driven low while master sets the mode fault flag
// - direction bit 5 makes select a plain output and stops fault checks
// - data and clock pins belong to the port while it is enabled
// - phase 0 shift clock is select or-ed with clock
// - phase 1 select may stay low between bytes
// - mode fault clears master bit and four port pin directions, requests interrupt
// - data write during a transfer flags collision and is dropped
// - collision detection works as master and as slave
// - master transfer runs from data write to completion flag
// - phase 0 slave transfer spans select low; flag at eighth cycle middle
// - phase 1 slave transfer runs from first active edge to completion flag
// - open-drain bit switches all six port pins to open drain
// - polarity bit sets master clock idle level
// - completion flag with interrupt enable raises a request
// - completion flag clears by status read then data access; writes gated
// - collision flag clears by status read then any data access
// - mode fault flag clears by status read then control write
// - completion flag set at end of every byte, master or slave
// - receive path double buffered, transmit single buffered
`default_nettype none

module spisp_top
	import spisp_pkg::*;
#(
	parameter int GAP_CYCLES = GAP_CYCLES_DEF
) (
	input wire logic i_clk, // system and e clock, 200 MHz
	input wire logic i_rst, // async reset, active high
	input wire logic [7:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [7:0] o_rdata, // read data, cycle after the strobe
	input wire logic i_ccr_irq_mask, // processor interrupt mask bit
	output logic o_irq_req, // interrupt request, active high
	input wire logic [5:0] i_pd_in, // port d pin levels
	output logic [5:0] o_pd_out, // port d pin output values
	output logic [5:0] o_pd_oe // port d pin output enables
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (GAP_CYCLES < 2 || GAP_CYCLES > 15) begin : g_bad_gap
		$error("GAP_CYCLES must lie between 2 and 15");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	logic [7:0] ctrl_reg;
	logic [5:0] pd_dir_reg;
	logic [5:0] pd_data_reg;
	logic [5:0] pd_s;
	logic tcf_reg, tcf_seen_reg;
	logic write_collision_flag_reg, write_collision_flag_seen_reg;
	logic mode_fault_flag_reg, mode_fault_flag_seen_reg;
	logic [7:0] sreg_reg;
	logic [7:0] rx_buf_reg;
	logic dout_reg;
	spisp_mstate_e mstate_reg;
	logic start_pend_reg;
	logic [4:0] div_cnt_reg;
	logic [3:0] edge_cnt_reg;
	logic sck_act_reg;
	logic [3:0] gap_cnt_reg;
	logic act_prev_reg;
	logic ss_prev_reg;
	logic [3:0] s_cnt_reg;
	logic s_active_reg;
	logic [5:0] pd_out_next, pd_oe_next, pd_oe_od;

	logic port_en, is_master, clock_polarity, clock_phase, ods;
	logic [1:0] rate;
	logic [4:0] half_m1;
	logic wr_ctl, wr_dir, wr_pdd, rd_sts, data_acc, wr_data;
	logic wr_allowed, xfer_busy, collide, load;
	logic sck_s, ss_s, din_s;
	logic tick, m_lead, m_trail, m_sample, m_drive, m_done;
	logic act_now, s_lead, s_trail, s_sample, s_drive, s_done, ss_fall;
	logic sample, drive, done, mode_fault;

	// ************************************************************
	// control fields and bus decode
	// ************************************************************
	assign port_en = ctrl_reg[CTL_PORT_EN];
	assign is_master = ctrl_reg[CTL_MASTER];
	assign clock_polarity = ctrl_reg[CTL_CLOCK_POLARITY];
	assign clock_phase = ctrl_reg[CTL_CLOCK_PHASE];
	assign ods = ctrl_reg[CTL_OPEN_DRAIN];
	assign rate = {ctrl_reg[CTL_RATE_HI], ctrl_reg[CTL_RATE_LO]};
	assign wr_ctl = i_wr && (i_addr == ADDR_CONTROL);
	assign wr_dir = i_wr && (i_addr == ADDR_PD_DIR);
	assign wr_pdd = i_wr && (i_addr == ADDR_PD_DATA);
	assign rd_sts = i_rd && (i_addr == ADDR_STATUS);
	assign data_acc = (i_rd || i_wr) && (i_addr == ADDR_DATA);
	assign wr_data = i_wr && (i_addr == ADDR_DATA);

	// half period of the master clock in e clocks, minus one
	always_comb begin
		case (rate)
			2'b00: half_m1 = 5'(RATE_DIV_0 / 2 - 1);
			2'b01: half_m1 = 5'(RATE_DIV_1 / 2 - 1);
			2'b10: half_m1 = 5'(RATE_DIV_2 / 2 - 1);
			2'b11: half_m1 = 5'(RATE_DIV_3 / 2 - 1);
			default: half_m1 = 5'(RATE_DIV_0 / 2 - 1);
		endcase
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	spisp_sync #(
		.WIDTH(PD_W),
		.RESET_VAL(PD_SYNC_RESET)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_pd_in),
		.o_q(pd_s)
	);

	assign sck_s = pd_s[PD_SCK];
	assign ss_s = pd_s[PD_SS];
	assign din_s = is_master ? pd_s[PD_MISO] : pd_s[PD_MOSI];

	// ************************************************************
	// write gating, collision and load
	// ************************************************************
	// a phase 0 slave is busy while selected, a phase 1 slave from its first edge
	assign xfer_busy = port_en && (is_master ? (mstate_reg == SPISP_M_SHIFT || start_pend_reg)
		: (clock_phase ? s_active_reg : !ss_s));
	assign wr_allowed = !tcf_reg || tcf_seen_reg;
	assign collide = wr_data && wr_allowed && xfer_busy;
	assign load = wr_data && wr_allowed && !xfer_busy;
	assign mode_fault = port_en && is_master && !pd_dir_reg[PD_SS] && !ss_s;

	// ************************************************************
	// master clock generator
	// ************************************************************
	assign tick = (mstate_reg == SPISP_M_SHIFT) && (div_cnt_reg == half_m1);
	assign m_lead = tick && !edge_cnt_reg[0];
	assign m_trail = tick && edge_cnt_reg[0];
	// data leaves on one edge and is latched on the other, half a clock later
	assign m_sample = clock_phase ? m_trail : m_lead;
	assign m_drive = clock_phase ? m_lead : m_trail;
	assign m_done = tick && (edge_cnt_reg == LAST_EDGE);

	// master sequencer: start on write, shift sixteen edges, then idle gap
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mstate_reg <= SPISP_M_IDLE;
		end else if (!port_en || !is_master) begin
			mstate_reg <= SPISP_M_IDLE;
		end else begin
			case (mstate_reg)
				SPISP_M_IDLE: begin
					if (start_pend_reg) begin
						mstate_reg <= SPISP_M_SHIFT;
					end
				end
				SPISP_M_SHIFT: begin
					if (m_done) begin
						mstate_reg <= SPISP_M_GAP;
					end
				end
				SPISP_M_GAP: begin
					if (gap_cnt_reg == 4'(GAP_CYCLES - 1)) begin
						mstate_reg <= SPISP_M_IDLE;
					end
				end
				default: mstate_reg <= SPISP_M_IDLE;
			endcase
		end
	end

	// pending start from a data write accepted in master mode
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			start_pend_reg <= 1'b0;
		end else if (!port_en || !is_master) begin
			start_pend_reg <= 1'b0;
		end else if (load) begin
			start_pend_reg <= 1'b1;
		end else if (mstate_reg == SPISP_M_IDLE) begin
			start_pend_reg <= 1'b0;
		end
	end

	// divider, edge counter and clock phase
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_cnt_reg <= 5'h00;
			edge_cnt_reg <= 4'h0;
			sck_act_reg <= 1'b0;
		end else if (mstate_reg != SPISP_M_SHIFT) begin
			div_cnt_reg <= 5'h00;
			edge_cnt_reg <= 4'h0;
			sck_act_reg <= 1'b0;
		end else if (tick) begin
			div_cnt_reg <= 5'h00;
			edge_cnt_reg <= edge_cnt_reg + 4'h1;
			sck_act_reg <= !sck_act_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 5'h01;
		end
	end

	// idle time between bytes with the clock at its rest level
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_cnt_reg <= 4'h0;
		end else if (mstate_reg == SPISP_M_GAP) begin
			gap_cnt_reg <= gap_cnt_reg + 4'h1;
		end else begin
			gap_cnt_reg <= 4'h0;
		end
	end

	// ************************************************************
	// slave edge detection
	// ************************************************************
	// select high holds the shift clock at rest, as an or of select and clock
	assign act_now = (sck_s ^ clock_polarity) && !ss_s;
	assign s_lead = act_now && !act_prev_reg;
	assign s_trail = !act_now && act_prev_reg;
	assign s_sample = port_en && !is_master && (clock_phase ? s_trail : s_lead);
	assign s_drive = port_en && !is_master && (clock_phase ? s_lead : s_trail);
	assign s_done = s_sample && (s_cnt_reg == (clock_phase ? LAST_EDGE : LAST_LEAD_EDGE));
	assign ss_fall = port_en && !is_master && !ss_s && ss_prev_reg;

	// previous levels for edge detection
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			act_prev_reg <= 1'b0;
			ss_prev_reg <= 1'b1;
		end else begin
			act_prev_reg <= act_now;
			ss_prev_reg <= ss_s;
		end
	end

	// slave edge count; phase 1 may keep select low and wraps per byte
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_cnt_reg <= 4'h0;
		end else if (ss_s || !port_en || is_master) begin
			s_cnt_reg <= 4'h0;
		end else if (s_done && clock_phase) begin
			s_cnt_reg <= 4'h0;
		end else if (s_lead || s_trail) begin
			s_cnt_reg <= s_cnt_reg + 4'h1;
		end
	end

	// phase 1 slave transfer window
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_active_reg <= 1'b0;
		end else if (!port_en || is_master || !clock_phase) begin
			s_active_reg <= 1'b0;
		end else if (s_done) begin
			s_active_reg <= 1'b0;
		end else if (s_lead && s_cnt_reg == 4'h0) begin
			s_active_reg <= 1'b1;
		end
	end

	// ************************************************************
	// shifter and receive buffer
	// ************************************************************
	assign sample = is_master ? m_sample : s_sample;
	assign drive = is_master ? m_drive : s_drive;
	assign done = port_en && (is_master ? m_done : s_done);

	// eight bits enter and leave the one shifter, msb first
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sreg_reg <= 8'h00;
		end else if (load) begin
			sreg_reg <= i_wdata;
		end else if (sample) begin
			sreg_reg <= {sreg_reg[6:0], din_s};
		end
	end

	// outgoing bit; a phase 0 slave shows its first bit as select falls
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			dout_reg <= 1'b0;
		end else if (load) begin
			dout_reg <= i_wdata[7];
		end else if (drive || ss_fall) begin
			dout_reg <= sreg_reg[7];
		end
	end

	// completed byte moves to the read buffer, freeing the shifter
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_buf_reg <= 8'h00;
		end else if (done) begin
			rx_buf_reg <= sample ? {sreg_reg[6:0], din_s} : sreg_reg;
		end
	end

	// ************************************************************
	// status flags; a setting event wins over a clear
	// ************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tcf_reg <= 1'b0;
			tcf_seen_reg <= 1'b0;
		end else if (done) begin
			tcf_reg <= 1'b1;
			tcf_seen_reg <= 1'b0;
		end else if (tcf_seen_reg && data_acc) begin
			tcf_reg <= 1'b0;
			tcf_seen_reg <= 1'b0;
		end else if (rd_sts && tcf_reg) begin
			tcf_seen_reg <= 1'b1;
		end
	end

	// collision flag
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			write_collision_flag_reg <= 1'b0;
			write_collision_flag_seen_reg <= 1'b0;
		end else if (collide) begin
			write_collision_flag_reg <= 1'b1;
			write_collision_flag_seen_reg <= 1'b0;
		end else if (write_collision_flag_seen_reg && data_acc) begin
			write_collision_flag_reg <= 1'b0;
			write_collision_flag_seen_reg <= 1'b0;
		end else if (rd_sts && write_collision_flag_reg) begin
			write_collision_flag_seen_reg <= 1'b1;
		end
	end

	// mode fault flag
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_fault_flag_reg <= 1'b0;
			mode_fault_flag_seen_reg <= 1'b0;
		end else if (mode_fault) begin
			mode_fault_flag_reg <= 1'b1;
			mode_fault_flag_seen_reg <= 1'b0;
		end else if (mode_fault_flag_seen_reg && wr_ctl) begin
			mode_fault_flag_reg <= 1'b0;
			mode_fault_flag_seen_reg <= 1'b0;
		end else if (rd_sts && mode_fault_flag_reg) begin
			mode_fault_flag_seen_reg <= 1'b1;
		end
	end

	// ************************************************************
	// control, direction and port data registers
	// ************************************************************
	// a fault forces slave mode even over a simultaneous write
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_reg <= CONTROL_RESET;
		end else begin
			if (wr_ctl) begin
				ctrl_reg <= i_wdata;
			end
			if (mode_fault) begin
				ctrl_reg[CTL_MASTER] <= 1'b0;
			end
		end
	end

	// pin directions; a fault releases the four port pins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pd_dir_reg <= PD_DIR_RESET;
		end else begin
			if (wr_dir) begin
				pd_dir_reg <= i_wdata[5:0];
			end
			if (mode_fault) begin
				pd_dir_reg[PD_SS:PD_MISO] <= 4'h0;
			end
		end
	end

	// general-purpose output values
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pd_data_reg <= PD_DATA_RESET;
		end else if (wr_pdd) begin
			pd_data_reg <= i_wdata[5:0];
		end
	end

	// ************************************************************
	// read port and interrupt request
	// ************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_CONTROL: o_rdata <= ctrl_reg;
				ADDR_STATUS: o_rdata <= {tcf_reg, write_collision_flag_reg, 1'b0, mode_fault_flag_reg, 4'h0};
				ADDR_DATA: o_rdata <= rx_buf_reg;
				ADDR_PD_DIR: o_rdata <= {2'b00, pd_dir_reg};
				ADDR_PD_DATA: o_rdata <= {2'b00, pd_s};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// request for completion or mode fault, gated by enable and processor mask
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_req <= 1'b0;
		end else begin
			o_irq_req <= ctrl_reg[CTL_IRQ_EN] && (tcf_reg || mode_fault_flag_reg) && !i_ccr_irq_mask;
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	// enabled port takes over data and clock pins from general-purpose use
	always_comb begin
		pd_out_next = pd_data_reg;
		pd_oe_next = pd_dir_reg;
		if (port_en) begin
			if (is_master) begin
				pd_oe_next[PD_MISO] = 1'b0;
				pd_out_next[PD_MOSI] = dout_reg;
				pd_out_next[PD_SCK] = clock_polarity ^ sck_act_reg;
				if (!pd_dir_reg[PD_SS]) begin
					pd_oe_next[PD_SS] = 1'b0;
				end
			end else begin
				pd_out_next[PD_MISO] = dout_reg;
				pd_oe_next[PD_MISO] = pd_dir_reg[PD_MISO] && !ss_s;
				pd_oe_next[PD_MOSI] = 1'b0;
				pd_oe_next[PD_SCK] = 1'b0;
				pd_oe_next[PD_SS] = 1'b0;
			end
		end
	end

	// open-drain mode only ever pulls a pin low
	for (genvar i = 0; i < PD_W; i++) begin : g_od
		assign pd_oe_od[i] = ods ? (pd_oe_next[i] && !pd_out_next[i]) : pd_oe_next[i];
	end

	// registered pin outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pd_out <= PD_DATA_RESET;
			o_pd_oe <= PD_DIR_RESET;
		end else begin
			o_pd_out <= pd_out_next;
			o_pd_oe <= pd_oe_od;
		end
	end

endmodule

`default_nettype wire

/* File: common/spisp_pkg.sv */
// constants shared by the serial port: register map, field positions,
// reset values, rate divisors and timing counts.
// assumes a single 200 MHz system clock that also serves as the e clock.
`default_nettype none

package spisp_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h29;
	localparam logic [7:0] ADDR_DATA = 8'h2A;
	localparam logic [7:0] ADDR_PD_DIR = 8'h2B;
	localparam logic [7:0] ADDR_PD_DATA = 8'h2C;

	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int CTL_IRQ_EN = 7;
	localparam int CTL_PORT_EN = 6;
	localparam int CTL_OPEN_DRAIN = 5;
	localparam int CTL_MASTER = 4;
	localparam int CTL_CLOCK_POLARITY = 3;
	localparam int CTL_CLOCK_PHASE = 2;
	localparam int CTL_RATE_HI = 1;
	localparam int CTL_RATE_LO = 0;

	// ************************************************************
	// status register fields
	// ************************************************************
	localparam int STS_TCF = 7;
	localparam int STS_WRITE_COLLISION_FLAG = 6;
	localparam int STS_MODE_FAULT_FLAG = 4;

	// ************************************************************
	// port d pin positions
	// ************************************************************
	localparam int PD_MISO = 2;
	localparam int PD_MOSI = 3;
	localparam int PD_SCK = 4;
	localparam int PD_SS = 5;
	localparam int PD_W = 6;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CONTROL_RESET = 8'h04;
	localparam logic [5:0] PD_DIR_RESET = 6'h00;
	localparam logic [5:0] PD_DATA_RESET = 6'h00;
	localparam logic [5:0] PD_SYNC_RESET = 6'h3F;

	// ************************************************************
	// rate divisors and timing
	// ************************************************************
	localparam logic [5:0] RATE_DIV_0 = 6'h02;
	localparam logic [5:0] RATE_DIV_1 = 6'h04;
	localparam logic [5:0] RATE_DIV_2 = 6'h10;
	localparam logic [5:0] RATE_DIV_3 = 6'h20;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	localparam logic [3:0] LAST_LEAD_EDGE = 4'hE;
	localparam int GAP_E_CYCLES = 2;
	localparam int E_CLK_PER_SYS_CLK = 1;
	localparam int GAP_CYCLES_DEF = GAP_E_CYCLES * E_CLK_PER_SYS_CLK;

	// master sequencer states
	typedef enum logic [1:0] {
		SPISP_M_IDLE = 2'b00,
		SPISP_M_SHIFT = 2'b01,
		SPISP_M_GAP = 2'b10
	} spisp_mstate_e;

endpackage

`default_nettype wire

/* File: src/spisp_sync.sv */
// two-stage synchroniser for a group of pin levels.
// assumes each bit is a slow level; bits are not coherent with each other.
`default_nettype none

module spisp_sync #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk, // system clock
	input wire logic i_rst, // async reset, active high
	input wire logic [WIDTH-1:0] i_d, // asynchronous levels
	output logic [WIDTH-1:0] o_q // synchronised levels
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= RESET_VAL;
			o_q <= RESET_VAL;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end

endmodule

`default_nettype wire

/* File: bench/spisp_slave_model.sv */
// behavioural far-side slave for the port in master mode.
// assumes clock, select and data come straight from the pins.
`default_nettype none
module spisp_slave_model (
	input wire logic i_sck, // serial clock pin
	input wire logic i_ss_n, // select, active low
	input wire logic i_mosi, // data from master
	input wire logic i_clock_polarity, // clock idle level
	input wire logic i_clock_phase, // clock phase
	input wire logic [7:0] i_tx, // byte to send
	output logic o_miso, // data to master
	output logic [7:0] o_rx // byte received
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh_reg = 8'h00;
	wire logic act = i_sck ^ i_clock_polarity;
	assign o_rx = sh_reg;
	initial o_miso = 1'b1;
	// load on select fall; phase 0 shows its first bit at once
	always @(negedge i_ss_n) begin
		sh_reg = i_tx;
		o_miso = i_tx[7];
	end
	// a released line shows the inverse of its last bit
	always @(posedge i_ss_n) o_miso = ~o_miso;
	// leading edge: phase 0 samples, phase 1 shows the next bit
	always @(posedge act) begin
		if (!i_ss_n && i_clock_phase) o_miso = sh_reg[7];
		else if (!i_ss_n) sh_reg = {sh_reg[6:0], i_mosi};
	end
	// trailing edge: the other half of the exchange
	always @(negedge act) begin
		if (!i_ss_n && i_clock_phase) sh_reg = {sh_reg[6:0], i_mosi};
		else if (!i_ss_n) o_miso = sh_reg[7];
	end
endmodule
`default_nettype wire

/* File: bench/spisp_top_checker.sv */
// concurrent checks on the ports of the serial port.
// assumes it is bound into spisp_top.
`default_nettype none
module spisp_top_checker
	import spisp_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst, // reset
	input wire logic [7:0] i_addr, // address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic [7:0] o_rdata, // read data
	input wire logic i_ccr_irq_mask, // irq mask
	input wire logic o_irq_req, // irq request
	input wire logic [5:0] i_pd_in, // pin levels
	input wire logic [5:0] o_pd_out, // pin values
	input wire logic [5:0] o_pd_oe // pin enables
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl_reg;
	logic [5:0] dir_reg;
	logic [3:0] age_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// shadow of control and direction writes, cycles since control write
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_reg <= CONTROL_RESET;
			dir_reg <= PD_DIR_RESET;
			age_reg <= 4'h0;
		end else begin
			if (i_wr && i_addr == ADDR_CONTROL) ctl_reg <= i_wdata;
			if (i_wr && i_addr == ADDR_PD_DIR) dir_reg <= i_wdata[5:0];
			age_reg <= (i_wr && i_addr == ADDR_CONTROL) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
		end
	end
	a_status_zeros: assert property (i_rd && i_addr == ADDR_STATUS |=> (o_rdata & 8'h2F) == 8'h00)
		else $error("status unused bits set");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_irq_masked: assert property (o_irq_req |-> $past(ctl_reg[CTL_IRQ_EN]) && !$past(i_ccr_irq_mask))
		else $error("irq without enable or while masked");
	a_miso_release: assert property ((!ctl_reg[CTL_MASTER] && ctl_reg[CTL_PORT_EN] && age_reg > 4'h3
		&& i_pd_in[PD_SS]) [*5] |-> !o_pd_oe[PD_MISO]) else $error("unselected slave drives data");
	a_open_drain: assert property (ctl_reg[CTL_OPEN_DRAIN] && age_reg > 4'h2 |-> (o_pd_oe & o_pd_out) == 6'h00)
		else $error("open drain pin drives high");
	a_rate_div: assert property (ctl_reg[CTL_MASTER] && ctl_reg[CTL_PORT_EN] && ctl_reg[1:0] == 2'b10
		&& age_reg > 4'h2 && $changed(o_pd_out[PD_SCK]) |=> $stable(o_pd_out[PD_SCK]) [*7])
		else $error("clock half period below 8");
	a_fault_release: assert property (ctl_reg[CTL_MASTER] && ctl_reg[CTL_PORT_EN] && !dir_reg[PD_SS]
		&& age_reg > 4'h3 && !i_pd_in[PD_SS] |-> ##[1:8] o_pd_oe[5:2] == 4'h0)
		else $error("fault left pins driven");
	a_fault_irq: assert property (ctl_reg[CTL_MASTER] && ctl_reg[CTL_IRQ_EN] && !dir_reg[PD_SS]
		&& age_reg > 4'h3 && !i_pd_in[PD_SS] && !i_ccr_irq_mask |-> ##[1:8] o_irq_req)
		else $error("fault raised no irq");
endmodule
bind spisp_top spisp_top_checker spisp_top_checker_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ccr_irq_mask(i_ccr_irq_mask),
	.o_irq_req(o_irq_req), .i_pd_in(i_pd_in), .o_pd_out(o_pd_out), .o_pd_oe(o_pd_oe));
`default_nettype wire

/* File: bench/test_spi_master_slave_port.sv */
// register-level bench for the serial port, master and slave roles.
// assumes a slave model on the pins, select driven as a port d output.
`default_nettype none
module test_spi_master_slave_port
	import spisp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mask = 1'b0;
	logic ss_ext = 1'b1, mpol = 1'b0, mpha = 1'b0, irq, miso, s_sck = 1'b0, s_mosi = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, mtx = 8'h00, rdata, mrx, sr = 8'h00;
	logic [5:0] pd_in, pd_out, pd_oe;
	int mismatches = 0, n_tests = 0, cycles = 0;
	// undriven pins: select, clock and data-out from bench, data-in from model, rest pulled up
	assign pd_in = (pd_oe & pd_out) | (~pd_oe & {ss_ext, s_sck, s_mosi, miso, 2'b11});
	spisp_top spisp_top_i (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_ccr_irq_mask(mask), .o_irq_req(irq), .i_pd_in(pd_in), .o_pd_out(pd_out),
		.o_pd_oe(pd_oe));
	spisp_slave_model spisp_slave_model_i (.i_sck(pd_in[PD_SCK]), .i_ss_n(pd_in[PD_SS]),
		.i_mosi(pd_in[PD_MOSI]), .i_clock_polarity(mpol), .i_clock_phase(mpha), .i_tx(mtx), .o_miso(miso), .o_rx(mrx));
	always #2.5 clk = ~clk;
	// hang guard, several times the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd8(a, d);
		cmp(d, e);
	endtask
	task automatic wait_tcf();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 200 && s[STS_TCF] !== 1'b1; i++) rd8(ADDR_STATUS, s);
	endtask
	// one byte each way, select pulsed high between bytes
	task automatic xfer(input logic [7:0] d, input logic [7:0] m);
		mtx = m;
		wr8(ADDR_PD_DATA, 8'h20);
		wr8(ADDR_PD_DATA, 8'h00);
		wr8(ADDR_DATA, d);
		wait_tcf();
		chk(ADDR_DATA, m);
		cmp(mrx, d);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		chk(ADDR_STATUS, 8'h00);
		chk(ADDR_CONTROL, CONTROL_RESET);
		wr8(ADDR_STATUS, 8'hFF);
		chk(ADDR_STATUS, 8'h00);
		wr8(ADDR_PD_DIR, 8'h04);
		wr8(ADDR_CONTROL, 8'h44);
		repeat (10) @(posedge clk);
		cmp({2'b00, pd_oe}, 8'h00);
		ss_ext <= 1'b0;
		repeat (6) @(posedge clk);
		cmp({2'b00, pd_oe}, 8'h04);
		ss_ext <= 1'b1;
		wr8(ADDR_PD_DIR, 8'h03);
		wr8(ADDR_PD_DATA, 8'h01);
		wr8(ADDR_CONTROL, 8'h24);
		repeat (4) @(posedge clk);
		cmp({2'b00, pd_oe}, 8'h02);
		wr8(ADDR_PD_DATA, 8'h20);
		wr8(ADDR_PD_DIR, 8'h38);
		// all four clock modes as master, slowest rate last
		for (int m = 0; m < 4; m++) begin
			mpol = m[1];
			mpha = m[0];
			wr8(ADDR_CONTROL, {4'h5, m[1:0], 1'b1, m[1] & m[0]});
			repeat (4) @(posedge clk);
			cmp({7'h00, pd_in[PD_SCK]}, {7'h00, mpol});
			xfer(8'h3C ^ m[7:0], 8'hA5 ^ m[7:0]);
		end
		// collision, irq, masking and an inhibited write
		wr8(ADDR_CONTROL, 8'hDF);
		mtx = 8'h5A;
		wr8(ADDR_PD_DATA, 8'h20);
		wr8(ADDR_PD_DATA, 8'h00);
		wr8(ADDR_DATA, 8'h96);
		wr8(ADDR_DATA, 8'h77);
		for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
		cmp({7'h00, irq}, 8'h01);
		mask <= 1'b1;
		repeat (2) @(posedge clk);
		cmp({7'h00, irq}, 8'h00);
		mask <= 1'b0;
		wr8(ADDR_DATA, 8'h11);
		repeat (40) @(posedge clk);
		cmp(mrx, 8'h96);
		chk(ADDR_STATUS, 8'hC0);
		chk(ADDR_DATA, 8'h5A);
		chk(ADDR_STATUS, 8'h00);
		// mode fault with select as an input
		wr8(ADDR_PD_DATA, 8'h20);
		wr8(ADDR_PD_DIR, 8'h18);
		ss_ext <= 1'b0;
		repeat (10) @(posedge clk);
		cmp({7'h00, irq}, 8'h01);
		chk(ADDR_STATUS, 8'h10);
		chk(ADDR_CONTROL, 8'hCF);
		chk(ADDR_PD_DIR, 8'h00);
		ss_ext <= 1'b1;
		wr8(ADDR_CONTROL, 8'h04);
		chk(ADDR_STATUS, 8'h00);
		// phase 1 slave byte clocked from the pins by the bench
		wr8(ADDR_PD_DIR, 8'h04);
		wr8(ADDR_DATA, 8'hC3);
		wr8(ADDR_CONTROL, 8'h44);
		sr <= 8'h6D;
		ss_ext <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			s_sck <= 1'b1;
			s_mosi <= sr[7];
			repeat (6) @(posedge clk);
			s_sck <= 1'b0;
			sr <= {sr[6:0], pd_in[PD_MISO]};
			repeat (6) @(posedge clk);
		end
		ss_ext <= 1'b1;
		repeat (6) @(posedge clk);
		chk(ADDR_STATUS, 8'h80);
		chk(ADDR_DATA, 8'h6D);
		cmp(sr, 8'hC3);
		complete_run();
	end
endmodule
`default_nettype wire
